// >>> pkg/cfs_map.svh
// Timing and geometry constants for the CCD frame clock sequencer.
// Assumes a 50 MHz mclk; included by bare name from pkg/.
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH

`define CFS_COLS        1100
`define CFS_ROWS        330
`define CFS_EXTRA       35
`define CFS_LEAD        19
`define CFS_STAGES      (`CFS_COLS + `CFS_EXTRA)
`define CFS_CLK_NS      20
`define CFS_PIX_MIN_NS  100
`define CFS_HALF        ((`CFS_PIX_MIN_NS / 2 + `CFS_CLK_NS - 1) / `CFS_CLK_NS)
`define CFS_PIX         (2 * `CFS_HALF)
`define CFS_VOVL_NS     5000
`define CFS_VSTEP       ((`CFS_VOVL_NS + `CFS_CLK_NS - 1) / `CFS_CLK_NS)
`define CFS_VLAST       5
`define CFS_PIX_W       16
`define CFS_FIFO_DEPTH  16

`endif

// >>> pkg/cfs_pkg.sv
// Types shared by the sequencer and its pixel buffer.
// Assumes cfs_map.svh is on the include path.
`include "cfs_map.svh"
package cfs_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_VSHIFT, ST_HREAD} cfs_state_e;
    typedef logic [`CFS_PIX_W-1:0] cfs_pix_t;
endpackage

// >>> pkg/cfs_stream_if.sv
// Valid/ready pixel stream between the sequencer and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cfs_stream_if;
    logic              valid;
    cfs_pkg::cfs_pix_t data;
    logic              ready;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> sim/cfs_ccd_model.sv
// Sensor model: turns transfer and reset gate activity into video samples.
// Assumes the sequencer's gate pins on a shared mclk; video carries a packet index.
`include "cfs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cfs_ccd_model (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  vert_phase_c,
    input  wire logic                  row_transfer_gate,
    input  wire logic                  sense_node_reset_gate,
    output logic [`CFS_PIX_W-1:0]      video_in
);
    logic [`CFS_PIX_W-1:0] pix_cnt_q;
    logic [7:0]            gap_q;
    logic                  rg_q;
    logic                  bad_q;
    wire                   rg_rise = sense_node_reset_gate && !rg_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rg_q  <= 1'b0;
            gap_q <= 8'hff;
            bad_q <= 1'b0;
        end else begin
            rg_q  <= sense_node_reset_gate;
            gap_q <= rg_rise ? 8'h00 : gap_q + ((gap_q == 8'hff) ? 8'h00 : 8'h01);
            // Packets faster than the amplifier settles come out scrambled
            if (rg_rise) begin
                bad_q <= (gap_q < 8'h04);
            end
        end
    end

    // Charge reaches the serial register only from under the third phase
    always_ff @(posedge mclk) begin
        if (rst) begin
            pix_cnt_q <= 16'h0000;
        end else if (row_transfer_gate && vert_phase_c) begin
            pix_cnt_q <= 16'h0000;
        end else if (rg_rise) begin
            pix_cnt_q <= pix_cnt_q + 16'h0001;
        end
    end

    assign video_in = bad_q ? ~pix_cnt_q : pix_cnt_q;
endmodule
`default_nettype wire

// >>> sim/tb_cfs_sequencer.sv
// Testbench for the frame clock sequencer: partial frames, each but the last cut by reset.
// Assumes cfs_map.svh on the include path and the sensor model beside the DUT.
`include "cfs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_cfs_sequencer;
    localparam int INTEG = 10;
    localparam int LIMIT = 80000;
    logic                  mclk, rst, ce, start, pinned_phase_mode, bin2_mode, pix_ready;
    logic [31:0]           integ_cycles;
    logic [8:0]            dump_lines;
    logic [`CFS_PIX_W-1:0] video_in, pix_data;
    logic                  vert_phase_a, vert_phase_b, vert_phase_c, row_transfer_gate;
    logic                  serial_phase_a, serial_phase_b, summing_well_gate;
    logic                  sense_node_reset_gate, lateral_dump_gate, shutter_open, busy, pix_valid;
    int                    bad_count, compares, cyc;
    cfs_pkg::cfs_pix_t     q[$];

    cfs_sequencer DUT (.mclk, .rst, .ce, .start, .pinned_phase_mode, .bin2_mode, .integ_cycles,
        .dump_lines, .video_in, .vert_phase_a, .vert_phase_b, .vert_phase_c, .row_transfer_gate,
        .serial_phase_a, .serial_phase_b, .summing_well_gate, .sense_node_reset_gate,
        .lateral_dump_gate, .shutter_open, .busy, .pix_valid, .pix_data, .pix_ready);
    cfs_ccd_model sensor (.mclk, .rst, .vert_phase_c, .row_transfer_gate, .sense_node_reset_gate,
        .video_in);

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (pix_valid === 1'b1 && pix_ready === 1'b1) q.push_back(pix_data);
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        q.delete();
    endtask

    task automatic launch(input logic p, input logic b, input logic [8:0] d);
        int n;
        logic [2:0] v0;
        pinned_phase_mode = p;
        bin2_mode = b;
        dump_lines = d;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        n = 0;
        while (shutter_open !== 1'b1 && n < 4) begin @(negedge mclk); n++; end
        check("busy", busy, 1'b1);
        n = 0;
        v0 = {vert_phase_a, vert_phase_b, vert_phase_c};
        check("integ rest", v0, p ? 3'h0 : 3'h6);
        while (shutter_open === 1'b1 && n < 1000) begin
            if ({vert_phase_a, vert_phase_b, vert_phase_c} !== v0) check("integ hold", 1, 0);
            @(negedge mclk);
            n++;
        end
        check("shutter cycles", n, INTEG + 1);
    endtask

    // Follows the vertical shifts of one line (two when binning) until the serial phases first move
    task automatic vshift(input logic dmp, output int tgs);
        logic [3:0] cur, prev, now;
        logic [1:0] s0;
        int len, n;
        tgs = 0; len = 0; n = 0; prev = 4'h0;
        s0 = {serial_phase_a, serial_phase_b};
        check("held serial", s0, dmp ? 2'h3 : 2'h2);
        cur = {vert_phase_a, vert_phase_b, vert_phase_c, row_transfer_gate};
        while ({serial_phase_a, serial_phase_b} === s0 && n < 5000) begin
            @(negedge mclk);
            n++; len++;
            now = {vert_phase_a, vert_phase_b, vert_phase_c, row_transfer_gate};
            if (now !== cur) begin
                if (now[0]) begin
                    check("dump gate", lateral_dump_gate, dmp);
                    check("shutter shut", shutter_open, 1'b0);
                    check("tg phases", now, 4'h3);
                    check("before tg", cur, 4'h6);
                end
                if (cur[0]) begin
                    tgs++;
                    check("tg width", len, `CFS_VSTEP);
                    check("after tg", now, 4'h8);
                end
                prev = cur; cur = now; len = 0;
            end
        end
    endtask

    // Window of 100 pixels starting at the first serial_phase_b rise
    task automatic shape(input logic p, input logic b);
        int rgs, ahi, sglo, arise;
        logic pa;
        logic [2:0] v0;
        rgs = 0; ahi = 0; sglo = 0; arise = 0; pa = serial_phase_a;
        v0 = {vert_phase_a, vert_phase_b, vert_phase_c};
        check("read vert", v0, p ? 3'h0 : 3'h6);
        repeat (600) begin
            @(negedge mclk);
            rgs += sense_node_reset_gate;
            ahi += serial_phase_a;
            sglo += !summing_well_gate;
            arise += (serial_phase_a && !pa) ? 1 : 0;
            pa = serial_phase_a;
            check("complement", serial_phase_a ^ serial_phase_b, 1'b1);
            check("vert hold", {vert_phase_a, vert_phase_b, vert_phase_c}, v0);
            if (!b) check("sum follows", summing_well_gate, serial_phase_b);
        end
        check("reset pulses", rgs, b ? 32'h32 : 32'h64);
        check("duty", ahi, 32'h12c);
        check("pixel rate", arise, 32'h64);
        check("sum low", sglo, b ? 32'h96 : 32'h12c);
    endtask

    // Runs to the next vertical change; optionally stalls the consumer
    task automatic finish_line(input int words, input int first, input int nb, input logic stall);
        int n, errs;
        logic pb;
        logic [1:0] s0;
        logic [3:0] v0;
        n = 0; errs = 0; pb = serial_phase_b; s0 = 2'h0;
        v0 = {vert_phase_a, vert_phase_b, vert_phase_c, row_transfer_gate};
        while ({vert_phase_a, vert_phase_b, vert_phase_c, row_transfer_gate} === v0
               && n < 9000) begin
            @(negedge mclk);
            n++;
            nb += (serial_phase_b && !pb) ? 1 : 0;
            pb = serial_phase_b;
            if (stall && n == 100) pix_ready = 1'b0;
            if (stall && n == 450) s0 = {serial_phase_a, serial_phase_b};
            if (stall && n > 450 && n < 550
                && ({serial_phase_a, serial_phase_b} !== s0 || pix_valid !== 1'b1)) errs++;
            if (stall && n == 550) pix_ready = 1'b1;
        end
        check("stall hold", errs, 0);
        check("line stages", nb, 32'h46f);
        check("words", q.size(), words);
        errs = 0;
        foreach (q[i]) if (q[i] !== q[0] + i) errs++;
        if (first >= 0 && q.size() > 0) check("first column", q[0], first);
        check("pixel order", errs, 0);
        check("drained", pix_valid, 1'b0);
        q.delete();
    endtask

    task automatic sc_normal();
        int t;
        launch(1'b0, 1'b0, 9'h000);
        vshift(1'b0, t);
        check("rows moved", t, 1);
        shape(1'b0, 1'b0);
        finish_line(32'h44c, 32'h14, 32'h65, 1'b1);
    endtask

    task automatic sc_pinned();
        int t;
        launch(1'b1, 1'b0, 9'h000);
        vshift(1'b0, t);
        check("rows moved", t, 1);
        shape(1'b1, 1'b0);
        finish_line(32'h44c, 32'h14, 32'h65, 1'b0);
    endtask

    task automatic sc_bin();
        int t;
        launch(1'b0, 1'b1, 9'h000);
        vshift(1'b0, t);
        check("rows binned", t, 2);
        shape(1'b0, 1'b1);
        finish_line(32'h226, -1, 32'h65, 1'b0);
    endtask

    task automatic sc_dump();
        int t;
        launch(1'b0, 1'b0, 9'h001);
        vshift(1'b1, t);
        check("rows dumped", t, 1);
        finish_line(0, -1, 0, 1'b0);
        vshift(1'b0, t);
        shape(1'b0, 1'b0);
        finish_line(32'h44c, 32'h14, 32'h65, 1'b0);
    endtask

    initial begin
        rst = 1'b1; ce = 1'b1; start = 1'b0; pinned_phase_mode = 1'b0; bin2_mode = 1'b0;
        integ_cycles = INTEG; dump_lines = 9'h000; pix_ready = 1'b1;
        bad_count = 0; compares = 0; cyc = 0;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        check("reset pins", {vert_phase_a, vert_phase_b, vert_phase_c, row_transfer_gate,
            serial_phase_a, serial_phase_b, summing_well_gate, sense_node_reset_gate,
            lateral_dump_gate, shutter_open, busy, pix_valid}, 12'h0a0);
        sc_normal();
        do_reset();
        sc_pinned();
        do_reset();
        sc_bin();
        do_reset();
        sc_dump();
        wrap_up();
    end
endmodule
`default_nettype wire

// >>> verilog/cfs_fifo.sv
// Pixel buffer: parameterised FIFO with a registered output stage.
// Assumes a synchronous active-high reset and a shared clock enable.
`include "cfs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cfs_fifo #(
    parameter int WIDTH = `CFS_PIX_W,
    parameter int DEPTH = `CFS_FIFO_DEPTH
) (
    input  wire logic   mclk,
    input  wire logic   rst,
    input  wire logic   ce,
    cfs_stream_if.snk   wr,
    cfs_stream_if.src   rd
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [CW-1:0]    cnt_q;
    logic             out_v_q;
    logic [WIDTH-1:0] out_d_q;
    logic             push;
    logic             pop;

    assign wr.ready = (cnt_q != CW'(DEPTH));
    assign push     = wr.valid && wr.ready;
    // Refill the output stage whenever it is empty or being drained
    assign pop      = (cnt_q != '0) && (!out_v_q || rd.ready);
    assign rd.valid = out_v_q;
    assign rd.data  = out_d_q;

    always_ff @(posedge mclk) begin
        if (push && ce) begin
            mem[wp_q] <= wr.data;
        end
        if (pop && ce) begin
            out_d_q <= mem[rp_q];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_q    <= '0;
            rp_q    <= '0;
            cnt_q   <= '0;
            out_v_q <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wp_q <= AW'(wp_q + 1'b1);
            end
            if (pop) begin
                rp_q <= AW'(rp_q + 1'b1);
            end
            cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
            if (pop) begin
                out_v_q <= 1'b1;
            end else if (rd.ready) begin
                out_v_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/cfs_sequencer.sv
// CCD frame clock sequencer: drives the vertical, transfer, serial, summing,
// reset and lateral dump gates and buffers digitised video samples.
// Assumes an external ADC on video_in, sampled asynchronously to mclk.
`include "cfs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cfs_sequencer (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    input  wire logic                     start,
    input  wire logic                     pinned_phase_mode,
    input  wire logic                     bin2_mode,
    input  wire logic [31:0]              integ_cycles,
    input  wire logic [8:0]               dump_lines,
    input  wire logic [`CFS_PIX_W-1:0]    video_in,
    output logic                          vert_phase_a,
    output logic                          vert_phase_b,
    output logic                          vert_phase_c,
    output logic                          row_transfer_gate,
    output logic                          serial_phase_a,
    output logic                          serial_phase_b,
    output logic                          summing_well_gate,
    output logic                          sense_node_reset_gate,
    output logic                          lateral_dump_gate,
    output logic                          shutter_open,
    output logic                          busy,
    output logic                          pix_valid,
    output logic [`CFS_PIX_W-1:0]         pix_data,
    input  wire logic                     pix_ready
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    cfs_pkg::cfs_state_e   state_q;
    logic [`CFS_PIX_W-1:0] vid_s1_q, vid_s2_q;
    logic                  mpp_q, bin_q, flush_q, vsub_q, pair_q;
    logic [8:0]            dump_left_q, row_q;
    logic [31:0]           integ_q;
    logic [2:0]            vstep_q, ph_q;
    logic [7:0]            vcnt_q;
    logic [10:0]           col_q;
    logic                  wr_valid_q;
    logic [`CFS_PIX_W-1:0] wr_data_q;
    logic                  va_d, vb_d, vc_d, tg_d, sa_d, sb_d, sg_d, rg_d, lg_d;
    logic                  pix_end, stall;

    cfs_stream_if wr_if ();
    cfs_stream_if rd_if ();

    // Vertical shift table {a, b, c, tg}
    function automatic logic [3:0] vert_step(input logic [2:0] s);
        unique case (s)
            3'h0:    vert_step = 4'hc;
            3'h1:    vert_step = 4'h4;
            3'h2:    vert_step = 4'h6;
            3'h3:    vert_step = 4'h3;
            3'h4:    vert_step = 4'h8;
            3'h5:    vert_step = 4'hc;
            default: vert_step = 4'hc;
        endcase
    endfunction

    function automatic logic in_image(input logic [10:0] c);
        in_image = (c >= 11'(`CFS_LEAD)) && (c < 11'(`CFS_LEAD + `CFS_COLS));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Video input synchroniser; ADC runs off its own timing
    always_ff @(posedge mclk) begin
        if (ce) begin
            vid_s1_q <= video_in;
            vid_s2_q <= vid_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencing
    assign pix_end = (ph_q == 3'(`CFS_PIX - 1));
    // Stalling at the pixel boundary keeps every phase full width
    assign stall   = (ph_q == 3'h0) && !wr_if.ready && !flush_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q     <= cfs_pkg::ST_IDLE;
            mpp_q       <= 1'b0;
            bin_q       <= 1'b0;
            flush_q     <= 1'b0;
            vsub_q      <= 1'b0;
            pair_q      <= 1'b0;
            dump_left_q <= '0;
            row_q       <= '0;
            integ_q     <= '0;
            vstep_q     <= '0;
            vcnt_q      <= '0;
            ph_q        <= '0;
            col_q       <= '0;
        end else if (ce) begin
            unique case (state_q)
                cfs_pkg::ST_IDLE: begin
                    if (start) begin
                        state_q     <= cfs_pkg::ST_INTEG;
                        mpp_q       <= pinned_phase_mode;
                        bin_q       <= bin2_mode;
                        dump_left_q <= dump_lines;
                        row_q       <= '0;
                        integ_q     <= '0;
                    end
                end
                cfs_pkg::ST_INTEG: begin
                    integ_q <= integ_q + 32'h1;
                    if (integ_q >= integ_cycles) begin
                        state_q <= cfs_pkg::ST_VSHIFT;
                        vstep_q <= '0;
                        vcnt_q  <= '0;
                        vsub_q  <= 1'b0;
                    end
                end
                cfs_pkg::ST_VSHIFT: begin
                    vcnt_q <= 8'(vcnt_q + 1'b1);
                    if (vcnt_q == 8'(`CFS_VSTEP - 1)) begin
                        vcnt_q  <= '0;
                        vstep_q <= 3'(vstep_q + 1'b1);
                        if (vstep_q == 3'(`CFS_VLAST)) begin
                            vstep_q <= '0;
                            row_q   <= 9'(row_q + 1'b1);
                            if (dump_left_q != '0) begin
                                dump_left_q <= 9'(dump_left_q - 1'b1);
                                if (dump_left_q == 9'h1 || row_q == 9'(`CFS_ROWS - 1)) begin
                                    state_q <= cfs_pkg::ST_HREAD;
                                    flush_q <= 1'b1;
                                    col_q   <= '0;
                                    ph_q    <= '0;
                                end
                            end else if (bin_q && !vsub_q) begin
                                vsub_q <= 1'b1;
                            end else begin
                                state_q <= cfs_pkg::ST_HREAD;
                                flush_q <= 1'b0;
                                col_q   <= '0;
                                ph_q    <= '0;
                                pair_q  <= 1'b0;
                            end
                        end
                    end
                end
                cfs_pkg::ST_HREAD: begin
                    if (!stall) begin
                        ph_q <= 3'(ph_q + 1'b1);
                        if (pix_end) begin
                            ph_q   <= '0;
                            pair_q <= bin_q && !pair_q;
                            if (col_q == 11'(`CFS_STAGES - 1)) begin
                                vsub_q  <= 1'b0;
                                state_q <= (row_q >= 9'(`CFS_ROWS)) ? cfs_pkg::ST_IDLE
                                                                    : cfs_pkg::ST_VSHIFT;
                            end else begin
                                col_q <= 11'(col_q + 1'b1);
                            end
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin levels
    always_comb begin
        logic [3:0] v;
        v    = vert_step(vstep_q);
        va_d = !mpp_q;
        vb_d = !mpp_q;
        vc_d = 1'b0;
        tg_d = 1'b0;
        sa_d = 1'b1;
        sb_d = 1'b0;
        sg_d = 1'b1;
        rg_d = 1'b0;
        lg_d = 1'b0;
        unique case (state_q)
            cfs_pkg::ST_IDLE, cfs_pkg::ST_INTEG: begin
            end
            cfs_pkg::ST_VSHIFT: begin
                {va_d, vb_d, vc_d, tg_d} = v;
                // Pinned rest is all low; leaving it on the line-end edge would
                // move verticals while the serial phases are still switching
                if (mpp_q && (vstep_q == 3'h0)) begin
                    {va_d, vb_d, vc_d} = 3'h0;
                end
                if (dump_left_q != '0) begin
                    sb_d = 1'b1;
                    lg_d = 1'b1;
                end
            end
            cfs_pkg::ST_HREAD: begin
                sa_d = (ph_q < 3'(`CFS_HALF));
                sb_d = !sa_d;
                // Tied to a serial phase per pixel, own pattern when binning
                sg_d = bin_q ? !(pair_q && !sa_d) : sb_d;
                rg_d = (ph_q == 3'h0) && !pair_q && !stall;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            vert_phase_a          <= 1'b0;
            vert_phase_b          <= 1'b0;
            vert_phase_c          <= 1'b0;
            row_transfer_gate     <= 1'b0;
            serial_phase_a        <= 1'b1;
            serial_phase_b        <= 1'b0;
            summing_well_gate     <= 1'b1;
            sense_node_reset_gate <= 1'b0;
            lateral_dump_gate     <= 1'b0;
            shutter_open          <= 1'b0;
            busy                  <= 1'b0;
        end else if (ce) begin
            vert_phase_a          <= va_d;
            vert_phase_b          <= vb_d;
            vert_phase_c          <= vc_d;
            row_transfer_gate     <= tg_d;
            serial_phase_a        <= sa_d;
            serial_phase_b        <= sb_d;
            summing_well_gate     <= sg_d;
            sense_node_reset_gate <= rg_d;
            lateral_dump_gate     <= lg_d;
            shutter_open          <= (state_q == cfs_pkg::ST_INTEG);
            busy                  <= (state_q != cfs_pkg::ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample capture into the buffer; one word per output pixel
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_valid_q <= 1'b0;
            wr_data_q  <= '0;
        end else if (ce) begin
            // A sample refused by a full buffer is held until taken, never dropped
            if (!(wr_valid_q && !wr_if.ready)) begin
                wr_valid_q <= (state_q == cfs_pkg::ST_HREAD) && pix_end && !flush_q
                              && in_image(col_q) && (!bin_q || pair_q);
                wr_data_q  <= vid_s2_q;
            end
        end
    end

    assign wr_if.valid = wr_valid_q && ce;
    assign wr_if.data  = wr_data_q;
    assign rd_if.ready = pix_ready;
    assign pix_valid   = rd_if.valid;
    assign pix_data    = rd_if.data;

    cfs_fifo #(.WIDTH(`CFS_PIX_W), .DEPTH(`CFS_FIFO_DEPTH)) u_fifo (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .wr   (wr_if),
        .rd   (rd_if)
    );

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_integ_static;
        @(posedge mclk) disable iff (rst)
        shutter_open && $past(shutter_open) |-> $stable({vert_phase_a, vert_phase_b, vert_phase_c});
    endproperty
    a_integ_static: assert property (p_integ_static) else $error("vertical moved in integration");

    property p_mpp_low;
        @(posedge mclk) disable iff (rst)
        mpp_q && (shutter_open || $changed(serial_phase_b)) |-> !(vert_phase_a || vert_phase_b || vert_phase_c);
    endproperty
    a_mpp_low: assert property (p_mpp_low) else $error("vertical high in pinned mode");

    property p_vert_quiet;
        @(posedge mclk) disable iff (rst)
        $changed({vert_phase_a, vert_phase_b, vert_phase_c}) |-> $stable({serial_phase_a, serial_phase_b});
    endproperty
    a_vert_quiet: assert property (p_vert_quiet) else $error("vertical change while serial moves");

    property p_tg_under_c;
        @(posedge mclk) disable iff (rst)
        row_transfer_gate |-> vert_phase_c && !vert_phase_a && !vert_phase_b && !shutter_open;
    endproperty
    a_tg_under_c: assert property (p_tg_under_c) else $error("transfer gate without charge under c");

    property p_half_width;
        @(posedge mclk) disable iff (rst || !ce)
        $rose(serial_phase_b) && !lateral_dump_gate |-> serial_phase_b[*3] ##1 !serial_phase_b;
    endproperty
    a_half_width: assert property (p_half_width) else $error("serial phase not 50 percent");

    property p_dump_high;
        @(posedge mclk) disable iff (rst)
        lateral_dump_gate |-> serial_phase_a && serial_phase_b;
    endproperty
    a_dump_high: assert property (p_dump_high) else $error("dump without serial phases high");

    property p_rg_pulse;
        @(posedge mclk) disable iff (rst || !ce)
        $rose(sense_node_reset_gate) |-> serial_phase_a ##1 !sense_node_reset_gate;
    endproperty
    a_rg_pulse: assert property (p_rg_pulse) else $error("reset gate pulse malformed");

    property p_line_len;
        @(posedge mclk) disable iff (rst)
        $fell(state_q == cfs_pkg::ST_HREAD) |-> col_q == 11'(`CFS_STAGES - 1);
    endproperty
    a_line_len: assert property (p_line_len) else $error("line shorter than 1135 stages");

    property p_bin_push;
        @(posedge mclk) disable iff (rst)
        wr_valid_q && bin_q |-> !$past(flush_q) && !pair_q;
    endproperty
    a_bin_push: assert property (p_bin_push) else $error("binned sample at wrong pixel");

    c_bin_frame: cover property (@(posedge mclk) bin_q && wr_valid_q);
    c_dump_line: cover property (@(posedge mclk) $fell(lateral_dump_gate));
    c_mpp_integ: cover property (@(posedge mclk) mpp_q && $fell(shutter_open));
    c_fifo_full: cover property (@(posedge mclk) !wr_if.ready);
endmodule
`default_nettype wire
